/* File: design/t2fb_control.sv */
// Overflow and external trigger flags, baud source selects and run control of timer two.
`default_nettype none
module t2fb_control
  import t2fb_pkg::*;
(
  input  wire logic                  i_clock,
  input  wire logic                  i_reset,
  input  wire logic                  i_ctrl_write,
  input  wire logic [CTRL_WIDTH-1:0] i_ctrl_wdata,
  output logic      [CTRL_WIDTH-1:0] o_ctrl_rdata,
  input  wire logic                  i_timer_two_overflow,
  input  wire logic                  i_timer_one_overflow,
  input  wire logic                  i_external_trigger_pin,
  output logic                       o_capture_reload,
  output logic                       o_timer_two_run,
  output logic                       o_rx_baud_clock,
  output logic                       o_tx_baud_clock,
  output logic                       o_irq
);
  logic ovf_q;
  logic ovf_d;
  logic ext_q;
  logic ext_d;
  logic rx_sel_q;
  logic rx_sel_d;
  logic tx_sel_q;
  logic tx_sel_d;
  logic ext_en_q;
  logic ext_en_d;
  logic run_q;
  logic run_d;
  logic [1:0] rest_q;
  logic [1:0] rest_d;
  logic fall;
  logic any_baud_sel;
  logic ovf_event;
  logic ext_event;

  t2fb_edge_detect u_edge
  (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_pin   (i_external_trigger_pin),
    .o_fall  (fall)
  );

  // Event qualification from the current selects and enable.
  assign any_baud_sel = rx_sel_q | tx_sel_q;
  assign ovf_event    = i_timer_two_overflow & ~any_baud_sel;
  assign ext_event    = fall & ext_en_q & ~any_baud_sel;

  // Software writes load every bit; a hardware set in the same cycle wins over a written zero.
  always_comb
  begin
    ovf_d    = ovf_q;
    ext_d    = ext_q;
    rx_sel_d = rx_sel_q;
    tx_sel_d = tx_sel_q;
    ext_en_d = ext_en_q;
    run_d    = run_q;
    rest_d   = rest_q;
    if (i_ctrl_write)
    begin
      ovf_d    = i_ctrl_wdata[BIT_OVF_FLAG];
      ext_d    = i_ctrl_wdata[BIT_EXT_FLAG];
      rx_sel_d = i_ctrl_wdata[BIT_RX_SEL];
      tx_sel_d = i_ctrl_wdata[BIT_TX_SEL];
      ext_en_d = i_ctrl_wdata[BIT_EXT_ENABLE];
      run_d    = i_ctrl_wdata[BIT_RUN];
      rest_d   = i_ctrl_wdata[1:0];
    end
    if (ovf_event)
    begin
      ovf_d = 1'h1;
    end
    if (ext_event)
    begin
      ext_d = 1'h1;
    end
  end

  // Register stage; all bits clear on reset.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      ovf_q    <= FLAG_RESET;
      ext_q    <= FLAG_RESET;
      rx_sel_q <= FLAG_RESET;
      tx_sel_q <= FLAG_RESET;
      ext_en_q <= FLAG_RESET;
      run_q    <= FLAG_RESET;
      rest_q   <= CTRL_RESET[1:0];
    end
    else
    begin
      ovf_q    <= ovf_d;
      ext_q    <= ext_d;
      rx_sel_q <= rx_sel_d;
      tx_sel_q <= tx_sel_d;
      ext_en_q <= ext_en_d;
      run_q    <= run_d;
      rest_q   <= rest_d;
    end
  end

  // Picks the overflow tick that clocks one serial direction; shared by both directions.
  function automatic logic baud_pick(input logic sel, input logic two_tick, input logic one_tick);
    baud_pick = sel ? two_tick : one_tick;
  endfunction

  // Read-back and outputs; baud muxes are combinational so ticks pass with no extra delay.
  assign o_ctrl_rdata     = {ovf_q, ext_q, rx_sel_q, tx_sel_q, ext_en_q, run_q, rest_q};
  assign o_capture_reload = ext_event;
  assign o_timer_two_run  = run_q;
  assign o_rx_baud_clock  = baud_pick(rx_sel_q, i_timer_two_overflow, i_timer_one_overflow);
  assign o_tx_baud_clock  = baud_pick(tx_sel_q, i_timer_two_overflow, i_timer_one_overflow);
  assign o_irq            = ovf_q | ext_q;

  property p_ovf_set;
    @(posedge i_clock) disable iff (i_reset)
      (i_timer_two_overflow && !rx_sel_q && !tx_sel_q) |=> ovf_q;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_blocked;
    @(posedge i_clock) disable iff (i_reset)
      (!ovf_q && !i_ctrl_write && (rx_sel_q || tx_sel_q)) |=> !ovf_q;
  endproperty
  a_ovf_blocked: assert property (p_ovf_blocked) else $error("overflow flag set while baud select active");

  property p_ovf_sticky;
    @(posedge i_clock) disable iff (i_reset)
      (ovf_q && !i_ctrl_write) |=> ovf_q;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag cleared without write");

  property p_ext_set;
    @(posedge i_clock) disable iff (i_reset)
      (fall && ext_en_q && !rx_sel_q && !tx_sel_q) |=> ext_q;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("trigger flag not set");

  property p_ext_sticky;
    @(posedge i_clock) disable iff (i_reset)
      (ext_q && !i_ctrl_write) |=> ext_q;
  endproperty
  a_ext_sticky: assert property (p_ext_sticky) else $error("trigger flag cleared without write");

  property p_rx_mux;
    @(posedge i_clock) disable iff (i_reset)
      o_rx_baud_clock == (o_ctrl_rdata[BIT_RX_SEL] ? i_timer_two_overflow : i_timer_one_overflow);
  endproperty
  a_rx_mux: assert property (p_rx_mux) else $error("receive baud source wrong");

  property p_tx_mux;
    @(posedge i_clock) disable iff (i_reset)
      o_tx_baud_clock == (o_ctrl_rdata[BIT_TX_SEL] ? i_timer_two_overflow : i_timer_one_overflow);
  endproperty
  a_tx_mux: assert property (p_tx_mux) else $error("transmit baud source wrong");

  property p_write_back;
    @(posedge i_clock) disable iff (i_reset)
      (i_ctrl_write && !i_timer_two_overflow && !fall) |=> (o_ctrl_rdata == $past(i_ctrl_wdata));
  endproperty
  a_write_back: assert property (p_write_back) else $error("written value not read back");

  property p_capture;
    @(posedge i_clock) disable iff (i_reset)
      o_capture_reload |-> (fall && o_ctrl_rdata[BIT_EXT_ENABLE] && !rx_sel_q && !tx_sel_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture without qualified edge");

  property p_run;
    @(posedge i_clock) disable iff (i_reset)
      (i_ctrl_write && !i_timer_two_overflow) |=> (o_timer_two_run == $past(i_ctrl_wdata[BIT_RUN]));
  endproperty
  a_run: assert property (p_run) else $error("run control not following write");

  property p_irq;
    @(posedge i_clock) disable iff (i_reset)
      o_irq == (o_ctrl_rdata[BIT_OVF_FLAG] || o_ctrl_rdata[BIT_EXT_FLAG]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  // Checked through reset itself, so this one has no disable clause.
  property p_reset_clear;
    @(posedge i_clock)
      i_reset |=> (o_ctrl_rdata == CTRL_RESET && !o_irq && !o_timer_two_run && !o_capture_reload);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("register not cleared by reset");

  property p_ovf_clear;
    @(posedge i_clock) disable iff (i_reset)
      (i_ctrl_write && !i_ctrl_wdata[BIT_OVF_FLAG] && !i_timer_two_overflow) |=> !ovf_q;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow flag not cleared by write");

  property p_ext_blocked;
    @(posedge i_clock) disable iff (i_reset)
      (!ext_q && !i_ctrl_write && (!ext_en_q || rx_sel_q || tx_sel_q)) |=> !ext_q;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked) else $error("trigger flag set without qualified edge");

  property p_capture_single;
    @(posedge i_clock) disable iff (i_reset)
      o_capture_reload |=> !o_capture_reload;
  endproperty
  a_capture_single: assert property (p_capture_single) else $error("capture pulse longer than one cycle");

  property p_run_hold;
    @(posedge i_clock) disable iff (i_reset)
      !i_ctrl_write |=> $stable(o_timer_two_run);
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("run control changed without write");
endmodule
`default_nettype wire

/* File: design/t2fb_pkg.sv */
// Package of bit positions, reset values and widths for the timer two flag and baud select block.
`default_nettype none
package t2fb_pkg;
  localparam int unsigned CTRL_WIDTH     = 8;
  localparam int unsigned BIT_OVF_FLAG   = 7;
  localparam int unsigned BIT_EXT_FLAG   = 6;
  localparam int unsigned BIT_RX_SEL     = 5;
  localparam int unsigned BIT_TX_SEL     = 4;
  localparam int unsigned BIT_EXT_ENABLE = 3;
  localparam int unsigned BIT_RUN        = 2;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic        FLAG_RESET     = 1'h0;
  localparam logic        PIN_IDLE       = 1'h1;
endpackage
`default_nettype wire

/* File: design/t2fb_edge_detect.sv */
// Two-flop synchroniser and falling edge detector for the external trigger pin.
`default_nettype none
module t2fb_edge_detect
  import t2fb_pkg::*;
(
  input  wire logic i_clock,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_fall
);
  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  // The first stage feeds only the second; the edge is taken between stages two and three.
  always_comb
  begin
    meta_d = i_pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // Idle level of the pin is high, so reset to one avoids a false edge after release.
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      meta_q <= PIN_IDLE;
      sync_q <= PIN_IDLE;
      prev_q <= PIN_IDLE;
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // One-cycle pulse on a high-to-low transition.
  assign o_fall = prev_q & ~sync_q;
endmodule
`default_nettype wire

/* File: verif/t2fb_bench.sv */
// Self-checking testbench for the timer two flag and baud select control block.
`default_nettype none
module t2fb_bench
  import t2fb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // Every input has a value at time zero; reset starts asserted and the pin idles high.
  logic       i_clock                = 1'h0;
  logic       i_reset                = 1'h1;
  logic       i_ctrl_write           = 1'h0;
  logic [7:0] i_ctrl_wdata           = 8'h00;
  logic       i_timer_two_overflow   = 1'h0;
  logic       i_timer_one_overflow   = 1'h0;
  logic       i_external_trigger_pin = 1'h1;
  logic [7:0] o_ctrl_rdata;
  logic       o_capture_reload;
  logic       o_timer_two_run;
  logic       o_rx_baud_clock;
  logic       o_tx_baud_clock;
  logic       o_irq;
  int         bad_count              = 0;
  int         checks_done            = 0;

  // A 50 ns period gives the 20 MHz system clock.
  always #25 i_clock = ~i_clock;

  t2fb_control u_dut (
    .i_clock                (i_clock),
    .i_reset                (i_reset),
    .i_ctrl_write           (i_ctrl_write),
    .i_ctrl_wdata           (i_ctrl_wdata),
    .o_ctrl_rdata           (o_ctrl_rdata),
    .i_timer_two_overflow   (i_timer_two_overflow),
    .i_timer_one_overflow   (i_timer_one_overflow),
    .i_external_trigger_pin (i_external_trigger_pin),
    .o_capture_reload       (o_capture_reload),
    .o_timer_two_run        (o_timer_two_run),
    .o_rx_baud_clock        (o_rx_baud_clock),
    .o_tx_baud_clock        (o_tx_baud_clock),
    .o_irq                  (o_irq)
  );

  // Compares with case equality so that an unknown never passes.
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One write strobe; returns at the falling edge after the value has landed.
  task automatic wr(input logic [7:0] d);
    @(posedge i_clock);
    i_ctrl_write <= 1'h1;
    i_ctrl_wdata <= d;
    @(posedge i_clock);
    i_ctrl_write <= 1'h0;
    @(negedge i_clock);
  endtask

  // Pulses one timer tick and looks at the baud clocks in that same cycle.
  task automatic tick(input logic two, input logic rx, input logic tx);
    @(posedge i_clock);
    i_timer_two_overflow <= two;
    i_timer_one_overflow <= ~two;
    @(negedge i_clock);
    chk("rx baud clock", {7'h00, o_rx_baud_clock}, {7'h00, rx});
    chk("tx baud clock", {7'h00, o_tx_baud_clock}, {7'h00, tx});
    @(posedge i_clock);
    i_timer_two_overflow <= 1'h0;
    i_timer_one_overflow <= 1'h0;
    @(negedge i_clock);
  endtask

  // Drops the pin once; the pulse count is taken over a fixed window, so nothing waits forever.
  task automatic fall(input logic [7:0] cfg, input logic [7:0] exp);
    int n;
    n = 0;
    wr(cfg);
    @(posedge i_clock);
    i_external_trigger_pin <= 1'h0;
    repeat (6)
    begin
      @(negedge i_clock);
      if (o_capture_reload === 1'h1)
        n++;
    end
    chk("capture pulses", n[7:0], exp);
    chk("trigger flag", {7'h00, o_ctrl_rdata[BIT_EXT_FLAG]}, exp);
    chk("irq", {7'h00, o_irq}, exp);
    repeat (5) @(negedge i_clock);
    chk("trigger flag held", {7'h00, o_ctrl_rdata[BIT_EXT_FLAG]}, exp);
    @(posedge i_clock);
    i_external_trigger_pin <= 1'h1;
    repeat (3) @(posedge i_clock);
    wr(8'h00);
    chk("irq after clear", {7'h00, o_irq}, 8'h00);
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence: reset, selects and overflow, software clear, then the trigger pin cases.
  initial
  begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'h0;
    @(negedge i_clock);
    chk("reset value", o_ctrl_rdata, CTRL_RESET);
    chk("irq at reset", {7'h00, o_irq}, 8'h00);
    wr(8'h33);
    chk("readback", o_ctrl_rdata, 8'h33);
    chk("run off", {7'h00, o_timer_two_run}, 8'h00);
    tick(1'h1, 1'h1, 1'h1);
    tick(1'h0, 1'h0, 1'h0);
    chk("both selects block flag", o_ctrl_rdata, 8'h33);
    wr(8'h24);
    chk("run on", {7'h00, o_timer_two_run}, 8'h01);
    tick(1'h1, 1'h1, 1'h0);
    tick(1'h0, 1'h0, 1'h1);
    chk("rx select blocks flag", o_ctrl_rdata, 8'h24);
    wr(8'h14);
    tick(1'h1, 1'h0, 1'h1);
    tick(1'h0, 1'h1, 1'h0);
    chk("tx select blocks flag", o_ctrl_rdata, 8'h14);
    wr(8'h04);
    tick(1'h0, 1'h1, 1'h1);
    tick(1'h1, 1'h0, 1'h0);
    chk("overflow flag", o_ctrl_rdata, 8'h84);
    chk("irq on overflow", {7'h00, o_irq}, 8'h01);
    repeat (4) @(negedge i_clock);
    chk("overflow flag held", o_ctrl_rdata, 8'h84);
    wr(8'h04);
    chk("overflow cleared", {7'h00, o_irq}, 8'h00);
    wr(8'hC0);
    chk("flags writable", {7'h00, o_irq}, 8'h01);
    wr(8'h00);
    fall(8'h08, 8'h01);
    fall(8'h00, 8'h00);
    fall(8'h28, 8'h00);
    fall(8'h18, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
